// *** logic/apl_config_bank.sv ***
/*
 * apl_config_bank: configuration register bank for the converter power
 * modes, serial output formatting, link parameters and global transfer.
 * Assumes a byte-wide synchronous register port driven by the serial
 * control port front end, sample data synchronous to clock, and a
 * synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module apl_config_bank #(
	parameter logic [7:0] LMFC_PERIOD = 8'h20, // counter wrap, frames
	parameter logic HD_VALUE = 1'b0, // fixed link HD value
	parameter logic [4:0] CF_VALUE = 5'h00 // fixed control words per frame
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// device pins and link events
	input wire logic power_down_pin,
	input wire logic sysref,
	input wire logic [7:0] lane_checksum_in,
	input wire logic lane_checksum_valid,
	// converter sample path
	input wire logic [apl_pkg::SAMPLE_W-1:0] sample_in,
	input wire logic sample_ctrl_in,
	output logic [apl_pkg::SAMPLE_W-1:0] sample_out,
	output logic [2:0] ctrl_bits_sel,
	// power and link controls
	output apl_pkg::apl_power_t conv_power,
	output apl_pkg::apl_power_t link_power,
	output apl_pkg::apl_link_ctrl_t link_ctrl,
	output logic driver_enable,
	output logic [7:0] lmfc_phase,
	output logic [7:0] preemphasis
);
	// staged registers written by the host
	logic [7:0] power_down_modes, next_power_down_modes;
	logic [7:0] output_mode, next_output_mode;
	logic [7:0] sync_sysref_control, next_sync_sysref_control;
	logic [7:0] lane_checksum, next_lane_checksum;
	logic [7:0] serial_driver_control, next_serial_driver_control;
	logic [7:0] multiframe_phase_offset, next_multiframe_phase_offset;
	logic [7:0] serial_preemphasis, next_serial_preemphasis;
	logic [7:0] resv_one, next_resv_one;
	logic [7:0] resv_two, next_resv_two;
	// active copies, updated by transfer
	logic [7:0] act_pdm, next_act_pdm;
	logic [7:0] act_om, next_act_om;
	logic [7:0] act_drv, next_act_drv;
	logic [7:0] act_lmfc, next_act_lmfc;
	logic [7:0] act_pre, next_act_pre;
	// read answer
	logic [7:0] next_reg_rdata;
	logic next_reg_rvalid;
	// transfer strobe
	logic transfer;

	assign transfer = reg_wr
		&& (reg_addr == apl_pkg::ADDR_GLOBAL_DEVICE_UPDATE)
		&& reg_wdata[apl_pkg::TRANSFER_BIT];

	// next values of the staged registers
	always_comb begin
		next_power_down_modes = power_down_modes;
		next_output_mode = output_mode;
		next_sync_sysref_control = sync_sysref_control;
		next_lane_checksum = lane_checksum;
		next_serial_driver_control = serial_driver_control;
		next_multiframe_phase_offset = multiframe_phase_offset;
		next_serial_preemphasis = serial_preemphasis;
		next_resv_one = resv_one;
		next_resv_two = resv_two;
		// checksum from the lane alignment data
		if (lane_checksum_valid) begin
			next_lane_checksum = lane_checksum_in;
		end
		if (reg_wr) begin
			unique case (reg_addr)
				apl_pkg::ADDR_POWER_DOWN_MODES: begin
					next_power_down_modes = {2'h0, reg_wdata[5:0]};
				end
				apl_pkg::ADDR_OUTPUT_MODE: begin
					// bit 3 is open
					next_output_mode = reg_wdata & 8'hF7;
				end
				apl_pkg::ADDR_SYNC_SYSREF_CONTROL: begin
					next_sync_sysref_control = reg_wdata;
				end
				apl_pkg::ADDR_LINK_RESERVED_FIELD_ONE: begin
					next_resv_one = reg_wdata;
				end
				apl_pkg::ADDR_LINK_RESERVED_FIELD_TWO: begin
					next_resv_two = reg_wdata;
				end
				apl_pkg::ADDR_LANE_CHECKSUM: begin
					// a host write overrides a same-cycle capture
					next_lane_checksum = reg_wdata;
				end
				apl_pkg::ADDR_SERIAL_DRIVER_CONTROL: begin
					next_serial_driver_control = {7'h00, reg_wdata[0]};
				end
				apl_pkg::ADDR_MULTIFRAME_PHASE_OFFSET: begin
					next_multiframe_phase_offset = reg_wdata;
				end
				apl_pkg::ADDR_SERIAL_PREEMPHASIS: begin
					next_serial_preemphasis = reg_wdata;
				end
				default: begin
					// read-only or unmapped: write ignored
				end
			endcase
		end
	end

	// staged registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			power_down_modes <= apl_pkg::RST_POWER_DOWN_MODES;
			output_mode <= apl_pkg::RST_OUTPUT_MODE;
			sync_sysref_control <= apl_pkg::RST_SYNC_SYSREF_CONTROL;
			lane_checksum <= apl_pkg::RST_LANE_CHECKSUM;
			serial_driver_control <= apl_pkg::RST_SERIAL_DRIVER_CONTROL;
			multiframe_phase_offset <= apl_pkg::RST_MULTIFRAME_PHASE_OFFSET;
			serial_preemphasis <= apl_pkg::RST_SERIAL_PREEMPHASIS;
			resv_one <= apl_pkg::RST_LINK_RESERVED;
			resv_two <= apl_pkg::RST_LINK_RESERVED;
		end else begin
			power_down_modes <= next_power_down_modes;
			output_mode <= next_output_mode;
			sync_sysref_control <= next_sync_sysref_control;
			lane_checksum <= next_lane_checksum;
			serial_driver_control <= next_serial_driver_control;
			multiframe_phase_offset <= next_multiframe_phase_offset;
			serial_preemphasis <= next_serial_preemphasis;
			resv_one <= next_resv_one;
			resv_two <= next_resv_two;
		end
	end

	// active copies take staged values only on transfer
	always_comb begin
		next_act_pdm = act_pdm;
		next_act_om = act_om;
		next_act_drv = act_drv;
		next_act_lmfc = act_lmfc;
		next_act_pre = act_pre;
		if (transfer) begin
			next_act_pdm = power_down_modes;
			next_act_om = output_mode;
			next_act_drv = serial_driver_control;
			next_act_lmfc = multiframe_phase_offset;
			next_act_pre = serial_preemphasis;
		end
	end

	// active configuration
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			act_pdm <= apl_pkg::RST_POWER_DOWN_MODES;
			act_om <= apl_pkg::RST_OUTPUT_MODE;
			act_drv <= apl_pkg::RST_SERIAL_DRIVER_CONTROL;
			act_lmfc <= apl_pkg::RST_MULTIFRAME_PHASE_OFFSET;
			act_pre <= apl_pkg::RST_SERIAL_PREEMPHASIS;
		end else begin
			act_pdm <= next_act_pdm;
			act_om <= next_act_om;
			act_drv <= next_act_drv;
			act_lmfc <= next_act_lmfc;
			act_pre <= next_act_pre;
		end
	end

	// read multiplexer; transfer bit always reads back zero
	always_comb begin
		next_reg_rvalid = reg_rd;
		next_reg_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				apl_pkg::ADDR_POWER_DOWN_MODES: next_reg_rdata = power_down_modes;
				apl_pkg::ADDR_OUTPUT_MODE: next_reg_rdata = output_mode;
				apl_pkg::ADDR_SYNC_SYSREF_CONTROL: begin
					next_reg_rdata = sync_sysref_control;
				end
				apl_pkg::ADDR_LINK_HD_CF_PARAMS: begin
					next_reg_rdata = {HD_VALUE, 2'h0, CF_VALUE};
				end
				apl_pkg::ADDR_LINK_RESERVED_FIELD_ONE: next_reg_rdata = resv_one;
				apl_pkg::ADDR_LINK_RESERVED_FIELD_TWO: next_reg_rdata = resv_two;
				apl_pkg::ADDR_LANE_CHECKSUM: next_reg_rdata = lane_checksum;
				apl_pkg::ADDR_SERIAL_DRIVER_CONTROL: begin
					next_reg_rdata = serial_driver_control;
				end
				apl_pkg::ADDR_MULTIFRAME_PHASE_OFFSET: begin
					next_reg_rdata = multiframe_phase_offset;
				end
				apl_pkg::ADDR_SERIAL_PREEMPHASIS: begin
					next_reg_rdata = serial_preemphasis;
				end
				default: next_reg_rdata = 8'h00; // unmapped and update reg
			endcase
		end
	end

	// output state computed from the active configuration
	apl_pkg::apl_power_t next_conv_power, next_link_power;
	apl_pkg::apl_link_ctrl_t next_link_ctrl;
	logic [apl_pkg::SAMPLE_W-1:0] next_sample_out;
	logic [7:0] next_lmfc_phase;
	logic pin_standby, link_standby_en;
	logic [1:0] link_field, conv_field, fmt;

	always_comb begin
		pin_standby = act_pdm[apl_pkg::PIN_STANDBY_BIT];
		link_standby_en = act_pdm[apl_pkg::LINK_STANDBY_BIT];
		link_field = act_pdm[apl_pkg::LINK_PWR_LSB +: 2];
		conv_field = act_pdm[apl_pkg::CONV_PWR_LSB +: 2];
		fmt = act_om[apl_pkg::FORMAT_LSB +: 2];
		// converter core power
		unique case (conv_field)
			apl_pkg::PWR_DOWN: next_conv_power = apl_pkg::APL_POWERED_DOWN;
			apl_pkg::PWR_STANDBY: next_conv_power = apl_pkg::APL_STANDBY;
			default: next_conv_power = apl_pkg::APL_RUN;
		endcase
		// pin overrides the converter field
		if (power_down_pin) begin
			next_conv_power = pin_standby ? apl_pkg::APL_STANDBY
				: apl_pkg::APL_POWERED_DOWN;
		end
		// link digital power
		unique case (link_field)
			apl_pkg::PWR_DOWN: next_link_power = apl_pkg::APL_POWERED_DOWN;
			apl_pkg::PWR_STANDBY: next_link_power = apl_pkg::APL_STANDBY;
			default: next_link_power = apl_pkg::APL_RUN;
		endcase
		if (power_down_pin) begin
			if (!pin_standby) begin
				next_link_power = apl_pkg::APL_POWERED_DOWN;
			end else if (link_standby_en
				&& next_link_power == apl_pkg::APL_RUN) begin
				next_link_power = apl_pkg::APL_STANDBY;
			end
		end
		// link circuit controls follow link power
		next_link_ctrl.pll_on = (next_link_power != apl_pkg::APL_POWERED_DOWN);
		next_link_ctrl.serializer_on = (next_link_power == apl_pkg::APL_RUN);
		next_link_ctrl.clocks_on = (next_link_power == apl_pkg::APL_RUN);
		next_link_ctrl.logic_reset = (next_link_power != apl_pkg::APL_RUN);
		// sample formatting
		next_sample_out = sample_in;
		if (fmt == apl_pkg::FMT_TWOS_COMPLEMENT) begin
			next_sample_out[apl_pkg::SAMPLE_W-1] =
				~sample_in[apl_pkg::SAMPLE_W-1];
		end
		if (act_om[apl_pkg::INVERT_BIT]) begin
			next_sample_out = ~next_sample_out;
		end
		if (act_om[apl_pkg::OUT_DISABLE_BIT]
			|| next_conv_power != apl_pkg::APL_RUN) begin
			next_sample_out = '0;
		end
		// phase counter: load offset on sysref, otherwise wrap count
		if (sysref) begin
			next_lmfc_phase = act_lmfc;
		end else if (lmfc_phase >= LMFC_PERIOD - 8'h01) begin
			next_lmfc_phase = 8'h00;
		end else begin
			next_lmfc_phase = lmfc_phase + 8'h01;
		end
	end

	// registered outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			conv_power <= apl_pkg::APL_RUN;
			link_power <= apl_pkg::APL_RUN;
			link_ctrl <= 4'h0;
			sample_out <= '0;
			ctrl_bits_sel <= 3'h0;
			driver_enable <= 1'b1;
			lmfc_phase <= apl_pkg::RST_MULTIFRAME_PHASE_OFFSET;
			preemphasis <= apl_pkg::RST_SERIAL_PREEMPHASIS;
		end else begin
			reg_rdata <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
			conv_power <= next_conv_power;
			link_power <= next_link_power;
			link_ctrl <= next_link_ctrl;
			sample_out <= next_sample_out;
			ctrl_bits_sel <= act_om[apl_pkg::CTRL_BITS_LSB +: 3];
			driver_enable <= ~act_drv[apl_pkg::DRIVER_PD_BIT];
			lmfc_phase <= next_lmfc_phase;
			preemphasis <= act_pre;
		end
	end
endmodule : apl_config_bank
`default_nettype wire

// *** logic/apl_pkg.sv ***
/*
 * apl_pkg: register map, field positions, reset values and mode codes
 * for the converter power and serial-output configuration bank.
 * Assumes a byte-wide register port and one 100 MHz clock domain.
 */
package apl_pkg;
	// register offsets
	localparam logic [7:0] ADDR_POWER_DOWN_MODES = 8'h08;
	localparam logic [7:0] ADDR_OUTPUT_MODE = 8'h14;
	localparam logic [7:0] ADDR_SYNC_SYSREF_CONTROL = 8'h3A;
	localparam logic [7:0] ADDR_LINK_HD_CF_PARAMS = 8'h75;
	localparam logic [7:0] ADDR_LINK_RESERVED_FIELD_ONE = 8'h76;
	localparam logic [7:0] ADDR_LINK_RESERVED_FIELD_TWO = 8'h77;
	localparam logic [7:0] ADDR_LANE_CHECKSUM = 8'h79;
	localparam logic [7:0] ADDR_SERIAL_DRIVER_CONTROL = 8'h80;
	localparam logic [7:0] ADDR_MULTIFRAME_PHASE_OFFSET = 8'h8B;
	localparam logic [7:0] ADDR_SERIAL_PREEMPHASIS = 8'hA8;
	localparam logic [7:0] ADDR_GLOBAL_DEVICE_UPDATE = 8'hFF;
	// reset values
	localparam logic [7:0] RST_POWER_DOWN_MODES = 8'h00;
	localparam logic [7:0] RST_OUTPUT_MODE = 8'h01;
	localparam logic [7:0] RST_SYNC_SYSREF_CONTROL = 8'h00;
	localparam logic [7:0] RST_LANE_CHECKSUM = 8'h00;
	localparam logic [7:0] RST_SERIAL_DRIVER_CONTROL = 8'h00;
	localparam logic [7:0] RST_MULTIFRAME_PHASE_OFFSET = 8'h00;
	localparam logic [7:0] RST_SERIAL_PREEMPHASIS = 8'h04;
	localparam logic [7:0] RST_LINK_RESERVED = 8'h00;
	// field positions
	localparam int PIN_STANDBY_BIT = 5;
	localparam int LINK_STANDBY_BIT = 4;
	localparam int LINK_PWR_LSB = 2;
	localparam int CONV_PWR_LSB = 0;
	localparam int CTRL_BITS_LSB = 5;
	localparam int OUT_DISABLE_BIT = 4;
	localparam int INVERT_BIT = 2;
	localparam int FORMAT_LSB = 0;
	localparam int DRIVER_PD_BIT = 0;
	localparam int TRANSFER_BIT = 0;
	localparam int SYNC_CTRL_MASK_HI = 5;
	// power field codes
	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_DOWN = 2'h1;
	localparam logic [1:0] PWR_STANDBY = 2'h2;
	// data format codes
	localparam logic [1:0] FMT_OFFSET_BINARY = 2'h0;
	localparam logic [1:0] FMT_TWOS_COMPLEMENT = 2'h1;
	// sample width
	localparam int SAMPLE_W = 11;

	// effective power state of one circuit group
	typedef enum logic [1:0] {
		APL_RUN,
		APL_POWERED_DOWN,
		APL_STANDBY
	} apl_power_t;

	// link digital circuitry controls
	typedef struct packed {
		logic pll_on;
		logic serializer_on;
		logic clocks_on;
		logic logic_reset;
	} apl_link_ctrl_t;

	// output formatting controls
	typedef struct packed {
		logic [2:0] ctrl_bits_sel;
		logic out_disable;
		logic invert;
		logic [1:0] format;
	} apl_format_t;
endpackage : apl_pkg

// *** test/apl_host.sv ***
/*
 * apl_host: host controller model on the register port of the bank.
 * Assumes one clock; requests change 1 ns after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module apl_host (
	// clock
	input wire logic clock,
	// register port toward the bank
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// idle port at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one strobe cycle; released lines show inverted junk, not old values
	task op(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : op
	// preemphasis codes are off 0x04 or on 0x14 only
	task wr(input logic [7:0] a, input logic [7:0] d);
		op(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		op(1'b0, a, 8'h00);
	endtask : rd
endmodule : apl_host
`default_nettype wire

// *** test/apl_config_bank_properties.sv ***
/*
 * apl_config_bank_properties: port-level checker for the config bank.
 * Assumes it is bound to apl_config_bank with matching parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module apl_config_bank_properties #(
	parameter logic [7:0] LMFC_PERIOD = 8'h20,
	parameter logic HD_VALUE = 1'b0,
	parameter logic [4:0] CF_VALUE = 5'h00
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// pins and outputs
	input wire logic power_down_pin,
	input wire logic sysref,
	input wire logic [7:0] lane_checksum_in,
	input wire logic lane_checksum_valid,
	input wire apl_pkg::apl_power_t conv_power,
	input wire apl_pkg::apl_power_t link_power,
	input wire apl_pkg::apl_link_ctrl_t link_ctrl,
	input wire logic [7:0] lmfc_phase
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	no_stray_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without read");
	hdcf_read_a: assert property (reg_rd && reg_addr == 8'h75
		|=> reg_rdata == {HD_VALUE, 2'b00, CF_VALUE}) else $error("bad hd cf");
	update_clear_a: assert property (reg_rd && reg_addr == 8'hFF
		|=> reg_rdata == 8'h00) else $error("transfer bit stuck");
	cksum_capture_a: assert property (lane_checksum_valid && !reg_wr
		##1 !lane_checksum_valid && !reg_wr
		##1 reg_rd && reg_addr == 8'h79
		|=> reg_rdata == $past(lane_checksum_in, 3))
		else $error("checksum not captured");
	lmfc_count_a: assert property (!sysref
		&& lmfc_phase < LMFC_PERIOD - 8'h01
		|=> lmfc_phase == $past(lmfc_phase) + 8'h01)
		else $error("phase stalled");
	lmfc_wrap_a: assert property (!sysref
		&& lmfc_phase >= LMFC_PERIOD - 8'h01
		|=> lmfc_phase == 8'h00) else $error("phase did not wrap");
	pin_power_a: assert property (power_down_pin
		|=> conv_power != apl_pkg::APL_RUN) else $error("pin ignored");
	link_ctrl_a: assert property (link_power != apl_pkg::APL_RUN |->
		{link_ctrl.serializer_on, link_ctrl.clocks_on,
		link_ctrl.logic_reset} == 3'h1
		&& link_ctrl.pll_on == (link_power == apl_pkg::APL_STANDBY))
		else $error("link controls wrong");
endmodule : apl_config_bank_properties
`default_nettype wire

// *** test/test_apl_config_bank.sv ***
/*
 * test_apl_config_bank: self-checking bench for the config bank.
 * Assumes apl_host drives the register port; reads are queued.
 */
`timescale 1ns/1ps
`default_nettype none
module test_apl_config_bank;
	logic clock, rst_n, pin, sysref, ck_v;
	logic reg_wr, reg_rd, reg_rvalid, driver_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ck_in, lmfc_phase, preemphasis;
	logic [7:0] o, cfg;
	logic [10:0] smp, sample_out;
	logic [2:0] ctrl_bits_sel;
	apl_pkg::apl_power_t conv_power, link_power;
	apl_pkg::apl_link_ctrl_t link_ctrl;
	logic [7:0] q[$]; // expected read data, oldest first
	int bad_count, samples_checked, r;
	// reset map and masked readback tables
	logic [7:0] ra[12] = '{8'h08, 8'h14, 8'h3A, 8'h79, 8'h80, 8'h8B,
		8'hA8, 8'h76, 8'h77, 8'h75, 8'hFF, 8'h10};
	logic [7:0] re[12] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h04, 8'h00, 8'h00, 8'h8A, 8'h00, 8'h00};
	logic [7:0] ma[4] = '{8'h08, 8'h14, 8'h80, 8'h75};
	logic [7:0] me[4] = '{8'h3F, 8'hF7, 8'h01, 8'h8A};
	logic [7:0] pv[3] = '{8'h00, 8'h20, 8'h30};
	logic [1:0] pc[3] = '{2'h1, 2'h2, 2'h2};
	logic [1:0] pl[3] = '{2'h1, 2'h0, 2'h2};
	apl_host host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	// non-zero link parameters so the read-only fields show up on reads
	apl_config_bank #(.HD_VALUE(1'b1), .CF_VALUE(5'h0A)) uut (.clock, .rst_n,
		.reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_rvalid, .power_down_pin(pin), .sysref,
		.lane_checksum_in(ck_in), .lane_checksum_valid(ck_v), .sample_in(smp),
		.sample_ctrl_in(1'b0), .sample_out, .ctrl_bits_sel, .conv_power,
		.link_power, .link_ctrl, .driver_enable, .lmfc_phase, .preemphasis);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task cmp(input logic [10:0] got, input logic [10:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task results;
		if (q.size() != 0) bad_count++;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task rdx(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		host.rd(a);
	endtask : rdx
	// copy staged settings, let outputs follow two edges later
	task xfer;
		host.wr(8'hFF, 8'h01);
		repeat (2) @(posedge clock);
		#1;
	endtask : xfer
	// answered reads are checked against the oldest note
	always @(negedge clock) begin
		if (reg_rvalid === 1'b1) begin
			if (q.size() == 0) cmp(11'h7FF, 11'h000);
			else cmp({3'h0, reg_rdata}, {3'h0, q.pop_front()});
		end
	end
	// hang guard
	initial begin
		#200000;
		bad_count++;
		results();
	end
	initial begin
		{rst_n, pin, sysref, ck_v, ck_in, smp} = '0;
		r = $urandom(14);
		repeat (10) @(posedge clock);
		#1 rst_n = 1'b1;
		foreach (ra[i]) rdx(ra[i], re[i]);
		cmp(preemphasis, 8'h04);
		cmp(driver_enable, 1'b1);
		foreach (ma[i]) begin
			host.wr(ma[i], 8'hFF);
			rdx(ma[i], me[i]);
		end
		// link is powered down around link setting changes
		host.wr(8'h08, 8'h04);
		xfer();
		cmp(link_power, apl_pkg::APL_POWERED_DOWN);
		host.wr(8'hA8, 8'h14);
		host.wr(8'h80, 8'h01);
		cmp(preemphasis, 8'h04);
		host.wr(8'h08, 8'h00);
		xfer();
		cmp(preemphasis, 8'h14);
		cmp(driver_enable, 1'b0);
		for (int i = 0; i < 3; i++) begin
			host.wr(8'h08, {4'h0, i[1:0], i[1:0]});
			xfer();
			cmp(conv_power, i[1:0]);
			cmp(link_power, i[1:0]);
			cmp(link_ctrl, i == 0 ? 4'hE : i == 1 ? 4'h1 : 4'h9);
		end
		foreach (pv[i]) begin
			host.wr(8'h08, pv[i]);
			xfer();
			pin = 1'b1;
			@(posedge clock);
			#1;
			cmp(conv_power, pc[i]);
			cmp(link_power, pl[i]);
			pin = 1'b0;
		end
		repeat (2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			cfg = {r[7:5], r[4], 1'b0, r[2], 1'b0, r[0]};
			host.wr(8'h14, cfg);
			xfer();
			smp = 11'($urandom);
			@(posedge clock);
			#1;
			cmp(sample_out, cfg[4] ? 11'h000 :
				smp ^ {cfg[0], 10'h000} ^ {11{cfg[2]}});
			cmp(ctrl_bits_sel, cfg[7:5]);
		end
		o = 8'($urandom % 32);
		host.wr(8'h8B, o);
		xfer();
		sysref = 1'b1;
		@(posedge clock);
		#1 sysref = 1'b0;
		cmp(lmfc_phase, o);
		ck_in = 8'($urandom);
		ck_v = 1'b1;
		@(posedge clock);
		#1 ck_v = 1'b0;
		rdx(8'h79, ck_in);
		repeat (3) @(posedge clock);
		results();
	end
endmodule : test_apl_config_bank
bind apl_config_bank apl_config_bank_properties #(.LMFC_PERIOD(LMFC_PERIOD),
	.HD_VALUE(HD_VALUE), .CF_VALUE(CF_VALUE)) props (.clock(clock),
	.rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.power_down_pin(power_down_pin), .sysref(sysref),
	.lane_checksum_in(lane_checksum_in),
	.lane_checksum_valid(lane_checksum_valid), .conv_power(conv_power),
	.link_power(link_power), .link_ctrl(link_ctrl), .lmfc_phase(lmfc_phase));
`default_nettype wire
